// ---- rtl/csbf_fabric.sv ----
`timescale 1ns/1ps
`include "csbf_params.svh"
// Notes on behaviour
// - Each program fetch or read returns one 16-bit word on the program read bus.
// - Program memory writes use only the low 16 bits of the core write bus.
// - Program memory is addressed by a 21-bit address; data returns on program bus.
// - Primary data reads return up to 32 bits, located by the primary address.
// - Primary 24-bit address serves byte, word, long and memory-mapped I/O.
// - Secondary word-only 24-bit address reads return on a 16-bit secondary bus.
// - RAM primary port is 32 bits; every other data port is 16 bits.
// - Peripheral bus reaches all registers at full rate, adding no wait cycles.
// - Peripheral writes take core write data; reads land on the primary read bus.
// - Byte accesses force the address top bit to zero, lower half only.
// - Flash control goes over the peripheral bus; flash data moves directly.
// - RAM serves primary and secondary reads in the same cycle.
module csbf_fabric
    import csbf_pkg::*;
#(
    parameter int PRI_AW = `CSBF_PRI_AW,
    parameter int PROG_AW = `CSBF_PROG_AW
)(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic prog_rd,
    input wire logic prog_wr,
    input wire logic [20:0] prog_addr,
    output logic [15:0] prog_rdata,
    output logic prog_rvalid,
    input wire csbf_pri_req_s pri_req,
    input wire logic [31:0] core_wdata,
    output logic [31:0] pri_rdata,
    output logic pri_rvalid,
    input wire logic sec_rd,
    input wire logic [23:0] secondary_data_addr,
    output logic [15:0] secondary_read_bus,
    output logic sec_rvalid,
    output logic pm_rd,
    output logic pm_wr,
    output logic [20:0] pm_addr,
    output logic [15:0] pm_wdata,
    input wire logic [15:0] pm_rdata,
    output logic ram_rd,
    output logic ram_wr,
    output logic [23:0] ram_addr,
    output logic [3:0] ram_be,
    output logic [31:0] ram_wdata,
    input wire logic [31:0] ram_rdata,
    output logic ram2_rd,
    output logic [23:0] ram2_addr,
    input wire logic [15:0] ram2_rdata,
    output csbf_tgt16_s flash_req,
    input wire logic [15:0] flash_rdata,
    output csbf_tgt16_s ext_req,
    input wire logic [15:0] ext_rdata,
    output csbf_tgt16_s peripheral_reg_bus,
    output logic fiu_ctl_sel,
    input wire logic [15:0] periph_rdata
);

    // ==========================================================
    // Elaboration checks
    if (PRI_AW != 24 || PROG_AW != 21) begin : g_bad_width
        $error("csbf_fabric: address widths are fixed at 24 and 21 bits");
    end

    // ==========================================================
    // Primary decode
    logic [23:0] pri_eff_addr;
    logic [23:0] pri_word_addr;
    logic pri_byte;
    logic pri_act;
    csbf_tgt_e pri_tgt;
    logic sec_in_ram;

    always_comb begin
        pri_byte = (pri_req.size == CSBF_SZ_BYTE);
        pri_act = pri_req.rd | pri_req.wr;
        pri_eff_addr = pri_req.addr;
        // Byte space lives in the lower half only
        if (pri_byte) begin
            pri_eff_addr[`CSBF_BYTE_MSB] = 1'b0;
        end
        pri_word_addr = pri_byte ? {1'b0, pri_eff_addr[23:1]} : pri_eff_addr;
        pri_tgt = CSBF_TGT_NONE;
        if (pri_act) begin
            if ((pri_word_addr & `CSBF_RAM_MASK) == `CSBF_RAM_BASE) begin
                pri_tgt = CSBF_TGT_RAM;
            end else if ((pri_word_addr & `CSBF_FLASH_MASK) == `CSBF_FLASH_BASE) begin
                pri_tgt = CSBF_TGT_FLASH;
            end else if ((pri_word_addr & `CSBF_PERIPH_MASK) == `CSBF_PERIPH_BASE) begin
                pri_tgt = CSBF_TGT_PERIPH;
            end else begin
                pri_tgt = CSBF_TGT_EXT;
            end
        end
        sec_in_ram = sec_rd && ((secondary_data_addr & `CSBF_RAM_MASK) == `CSBF_RAM_BASE);
    end

    // ==========================================================
    // Target strobes, all in the request cycle
    logic [15:0] wlane;

    always_comb begin
        // Narrow writes place the byte on both lanes so the enable picks it
        wlane = pri_byte ? {core_wdata[7:0], core_wdata[7:0]} : core_wdata[15:0];
        pm_rd = prog_rd;
        pm_wr = prog_wr;
        pm_addr = prog_addr;
        pm_wdata = core_wdata[15:0];
        ram_rd = pri_req.rd && (pri_tgt == CSBF_TGT_RAM);
        ram_wr = pri_req.wr && (pri_tgt == CSBF_TGT_RAM);
        ram_addr = pri_word_addr;
        unique case (pri_req.size)
            CSBF_SZ_BYTE: ram_be = pri_eff_addr[0] ? `CSBF_BE_BYTE1 : `CSBF_BE_BYTE0;
            CSBF_SZ_LONG: ram_be = `CSBF_BE_LONG;
            default: ram_be = `CSBF_BE_WORD;
        endcase
        ram_wdata = {core_wdata[31:16], wlane};
        ram2_rd = sec_in_ram;
        ram2_addr = secondary_data_addr;
        flash_req.rd = pri_req.rd && (pri_tgt == CSBF_TGT_FLASH);
        flash_req.wr = pri_req.wr && (pri_tgt == CSBF_TGT_FLASH);
        flash_req.addr = pri_word_addr;
        flash_req.wdata = wlane;
        ext_req.rd = pri_req.rd && (pri_tgt == CSBF_TGT_EXT);
        ext_req.wr = pri_req.wr && (pri_tgt == CSBF_TGT_EXT);
        ext_req.addr = pri_word_addr;
        ext_req.wdata = wlane;
        peripheral_reg_bus.rd = pri_req.rd && (pri_tgt == CSBF_TGT_PERIPH);
        peripheral_reg_bus.wr = pri_req.wr && (pri_tgt == CSBF_TGT_PERIPH);
        peripheral_reg_bus.addr = pri_word_addr;
        peripheral_reg_bus.wdata = wlane;
        fiu_ctl_sel = (pri_tgt == CSBF_TGT_PERIPH)
            && ((pri_word_addr & `CSBF_FIU_MASK) == `CSBF_FIU_BASE);
    end

    // ==========================================================
    // Read return path: one fixed cycle for every target, no waits
    logic [15:0] prog_rdata_reg, prog_rdata_next;
    logic prog_rvalid_reg, prog_rvalid_next;
    logic [31:0] pri_rdata_reg, pri_rdata_next;
    logic pri_rvalid_reg, pri_rvalid_next;
    logic [15:0] sec_rdata_reg, sec_rdata_next;
    logic sec_rvalid_reg, sec_rvalid_next;
    logic [15:0] tgt16;

    always_comb begin
        prog_rvalid_next = prog_rd;
        prog_rdata_next = prog_rd ? pm_rdata : prog_rdata_reg;
        unique case (pri_tgt)
            CSBF_TGT_FLASH: tgt16 = flash_rdata;
            CSBF_TGT_PERIPH: tgt16 = periph_rdata;
            CSBF_TGT_EXT: tgt16 = ext_rdata;
            default: tgt16 = 16'h0000;
        endcase
        pri_rvalid_next = pri_req.rd;
        pri_rdata_next = pri_rdata_reg;
        if (pri_req.rd) begin
            if (pri_tgt == CSBF_TGT_RAM) begin
                unique case (pri_req.size)
                    CSBF_SZ_BYTE: pri_rdata_next = {24'h000000,
                        pri_eff_addr[0] ? ram_rdata[15:8] : ram_rdata[7:0]};
                    CSBF_SZ_LONG: pri_rdata_next = ram_rdata;
                    default: pri_rdata_next = {16'h0000, ram_rdata[15:0]};
                endcase
            end else if (pri_byte) begin
                pri_rdata_next = {24'h000000, pri_eff_addr[0] ? tgt16[15:8] : tgt16[7:0]};
            end else begin
                pri_rdata_next = {16'h0000, tgt16};
            end
        end
        sec_rvalid_next = sec_rd;
        sec_rdata_next = sec_rdata_reg;
        if (sec_rd) begin
            // Only the RAM has a second read port; elsewhere reads as zero
            sec_rdata_next = sec_in_ram ? ram2_rdata : 16'h0000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prog_rdata_reg <= 16'h0000;
            prog_rvalid_reg <= 1'b0;
            pri_rdata_reg <= 32'h00000000;
            pri_rvalid_reg <= 1'b0;
            sec_rdata_reg <= 16'h0000;
            sec_rvalid_reg <= 1'b0;
        end else begin
            prog_rdata_reg <= prog_rdata_next;
            prog_rvalid_reg <= prog_rvalid_next;
            pri_rdata_reg <= pri_rdata_next;
            pri_rvalid_reg <= pri_rvalid_next;
            sec_rdata_reg <= sec_rdata_next;
            sec_rvalid_reg <= sec_rvalid_next;
        end
    end

    assign prog_rdata = prog_rdata_reg;
    assign prog_rvalid = prog_rvalid_reg;
    assign pri_rdata = pri_rdata_reg;
    assign pri_rvalid = pri_rvalid_reg;
    assign secondary_read_bus = sec_rdata_reg;
    assign sec_rvalid = sec_rvalid_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    property p_prog_ret;
        prog_rd |=> prog_rvalid && (prog_rdata == $past(pm_rdata));
    endproperty
    a_prog_ret: assert property (p_prog_ret) else $error("program word not returned");

    property p_prog_wr_low;
        prog_wr |-> pm_wr && (pm_wdata == core_wdata[15:0]);
    endproperty
    a_prog_wr_low: assert property (p_prog_wr_low) else $error("program write data not low half");

    property p_prog_addr;
        (prog_rd || prog_wr) |-> (pm_addr == prog_addr) && (pm_rd == prog_rd);
    endproperty
    a_prog_addr: assert property (p_prog_addr) else $error("program address not passed");

    property p_long_ret;
        (pri_req.rd && pri_req.size == CSBF_SZ_LONG && ram_rd) |=> pri_rvalid
            && (pri_rdata == $past(ram_rdata));
    endproperty
    a_long_ret: assert property (p_long_ret) else $error("long read data wrong");

    property p_byte_low;
        (pri_act && pri_byte) |-> !pri_eff_addr[23] && !pri_word_addr[23] && !pri_word_addr[22];
    endproperty
    a_byte_low: assert property (p_byte_low) else $error("byte access reached upper half");

    property p_dual_read;
        (ram_rd && sec_in_ram) |-> ram2_rd ##1 (pri_rvalid && sec_rvalid
            && secondary_read_bus == $past(ram2_rdata));
    endproperty
    a_dual_read: assert property (p_dual_read) else $error("dual read not served together");

    property p_periph_path;
        peripheral_reg_bus.rd && !pri_byte |=> pri_rvalid && (pri_rdata == {16'h0000, $past(periph_rdata)});
    endproperty
    a_periph_path: assert property (p_periph_path) else $error("peripheral read lost or delayed");

    property p_one_target;
        $onehot0({ram_rd | ram_wr, flash_req.rd | flash_req.wr, ext_req.rd | ext_req.wr,
            peripheral_reg_bus.rd | peripheral_reg_bus.wr}) && (pri_act == (pri_tgt != CSBF_TGT_NONE));
    endproperty
    a_one_target: assert property (p_one_target) else $error("access routed to several targets");

    property p_long_be;
        (ram_wr && pri_req.size == CSBF_SZ_LONG) |-> (ram_be == `CSBF_BE_LONG)
            && (ram_wdata == core_wdata);
    endproperty
    a_long_be: assert property (p_long_be) else $error("long write not full width");

endmodule

// ---- inc/csbf_params.svh ----
`ifndef CSBF_PARAMS_SVH
`define CSBF_PARAMS_SVH

// ==========================================================
// Address regions of the primary data space (word addresses)
`define CSBF_RAM_BASE 24'h000000
`define CSBF_RAM_MASK 24'hFFF000
`define CSBF_FLASH_BASE 24'h004000
`define CSBF_FLASH_MASK 24'hFFF000
`define CSBF_PERIPH_BASE 24'h00F000
`define CSBF_PERIPH_MASK 24'hFFF000
`define CSBF_FIU_BASE 24'h00F400
`define CSBF_FIU_MASK 24'hFFFFC0

// ==========================================================
// Byte lane enables of the 32-bit RAM primary port
`define CSBF_BE_BYTE0 4'h1
`define CSBF_BE_BYTE1 4'h2
`define CSBF_BE_WORD 4'h3
`define CSBF_BE_LONG 4'hF

// ==========================================================
// Bus widths
`define CSBF_PRI_AW 24
`define CSBF_PROG_AW 21
`define CSBF_BYTE_MSB 23

`endif

// ---- inc/csbf_pkg.sv ----
package csbf_pkg;

    typedef enum logic [1:0] {
        CSBF_SZ_BYTE = 2'h0,
        CSBF_SZ_WORD = 2'h1,
        CSBF_SZ_LONG = 2'h2
    } csbf_size_e;

    typedef enum logic [2:0] {
        CSBF_TGT_NONE = 3'h0,
        CSBF_TGT_RAM = 3'h1,
        CSBF_TGT_FLASH = 3'h2,
        CSBF_TGT_PERIPH = 3'h3,
        CSBF_TGT_EXT = 3'h4
    } csbf_tgt_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [1:0] size;
        logic [23:0] addr;
    } csbf_pri_req_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] wdata;
        logic [23:0] addr;
    } csbf_tgt16_s;

endpackage

// ---- verification/csbf_mem_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Memories and peripherals behind the fabric, asynchronous read
module csbf_mem_model
    import csbf_pkg::*;
(
    input wire logic pm_rd,
    input wire logic [20:0] pm_addr,
    output logic [15:0] pm_rdata,
    input wire logic ram_rd,
    input wire logic [23:0] ram_addr,
    output logic [31:0] ram_rdata,
    input wire logic ram2_rd,
    input wire logic [23:0] ram2_addr,
    output logic [15:0] ram2_rdata,
    input wire csbf_tgt16_s flash_req,
    output logic [15:0] flash_rdata,
    input wire csbf_tgt16_s ext_req,
    output logic [15:0] ext_rdata,
    input wire csbf_tgt16_s peripheral_reg_bus,
    output logic [15:0] periph_rdata
);
    // Unselected ports show inverted data, so a read taken from an idle port mismatches
    function automatic logic [15:0] pat(input logic en, input logic [23:0] a, input logic [15:0] k);
        return en ? (a[15:0] ^ k) : ~(a[15:0] ^ k);
    endfunction

    always_comb begin
        pm_rdata = pat(pm_rd, {3'h0, pm_addr}, 16'h5A5A);
        ram_rdata = {pat(ram_rd, ram_addr, 16'h1234), pat(ram_rd, ram_addr, 16'h0000)};
        ram2_rdata = pat(ram2_rd, ram2_addr, 16'h0F0F);
        flash_rdata = pat(flash_req.rd, flash_req.addr, 16'h3C3C);
        ext_rdata = pat(ext_req.rd, ext_req.addr, 16'hC3C3);
        periph_rdata = pat(peripheral_reg_bus.rd, peripheral_reg_bus.addr, 16'h6969);
    end
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`include "csbf_params.svh"
module testbench
    import csbf_pkg::*;
;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic prog_rd = 1'b0, prog_wr = 1'b0, sec_rd = 1'b0;
    logic [20:0] prog_addr = '0;
    logic [31:0] core_wdata = '0, seed = 32'hF8A3;
    logic [23:0] secondary_data_addr = '0;
    csbf_pri_req_s pri_req = '0;
    logic [15:0] prog_rdata, secondary_read_bus, pm_wdata, pm_rdata, ram2_rdata, flash_rdata, ext_rdata, periph_rdata;
    logic [31:0] pri_rdata, ram_wdata, ram_rdata;
    logic prog_rvalid, pri_rvalid, sec_rvalid, pm_rd, pm_wr, ram_rd, ram_wr, ram2_rd, fiu_ctl_sel;
    logic [20:0] pm_addr;
    logic [23:0] ram_addr, ram2_addr;
    logic [3:0] ram_be;
    csbf_tgt16_s flash_req, ext_req, peripheral_reg_bus;
    logic [63:0] qp[$], qr[$], qs[$];
    int err_count = 0, n_checks = 0, cyc = 0;
    localparam logic [23:0] BASE [5] = '{24'h000000, 24'h004000, 24'h00F000, 24'h00F400, 24'h020000};
    localparam logic [23:0] MSK [5] = '{24'hFFF, 24'hFFF, 24'hFFF, 24'h3F, 24'hFFFF};

    csbf_fabric dut_u (.*);
    csbf_mem_model mem_u (.*);

    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    // ==========================================================
    // Helpers
    function automatic logic [15:0] ex(input logic [23:0] a, input logic [15:0] k);
        return a[15:0] ^ k;
    endfunction

    function logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task print_verdict();
        $display("errors %0d, checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Every registered output is zero right after reset
    task chk_idle();
        chk(64'({prog_rvalid, pri_rvalid, sec_rvalid, prog_rdata, secondary_read_bus}), 64'h0);
        chk(64'(pri_rdata), 64'h0);
    endtask

    // Each note carries the cycle its answer is due, so a late answer fails too
    task automatic take(ref logic [63:0] q[$], input logic [31:0] v);
        if (q.size() == 0)
            chk(64'h1, 64'h0);
        else
            chk({cyc, v}, q.pop_front());
    endtask

    // ==========================================================
    // Drivers
    task prog_op(input logic rd, input logic [20:0] a);
        logic [31:0] d;
        d = nxt();
        @(posedge ref_clk);
        prog_rd <= rd;
        prog_wr <= ~rd;
        prog_addr <= a;
        core_wdata <= d;
        pri_req <= '0;
        sec_rd <= 1'b0;
        #1;
        chk(64'({pm_rd, pm_wr, pm_addr}), 64'({rd, ~rd, a}));
        if (!rd) chk(64'(pm_wdata), 64'(d[15:0]));
        if (rd) qp.push_back({cyc + 1, 16'h0, ex({3'h0, a}, 16'h5A5A)});
    endtask

    task pri_op(input logic [1:0] sz, input int t);
        logic [31:0] r, w, d, e;
        logic [23:0] wa, a, sa;
        logic [3:0] tg;
        logic [39:0] tw;
        r = nxt();
        w = nxt();
        wa = BASE[t] + (r[31:8] & MSK[t]);
        a = (sz == 2'h0) ? {r[2], wa[21:0], r[3]} : wa;
        sa = r[4] ? {12'h0, r[19:8]} : {8'h01, r[23:8]};
        tg = ((wa & `CSBF_RAM_MASK) == `CSBF_RAM_BASE) ? 4'h8 :
             ((wa & `CSBF_FLASH_MASK) == `CSBF_FLASH_BASE) ? 4'h4 :
             ((wa & `CSBF_PERIPH_MASK) == `CSBF_PERIPH_BASE) ? 4'h2 : 4'h1;
        @(posedge ref_clk);
        prog_rd <= 1'b0;
        prog_wr <= 1'b0;
        pri_req <= {r[0], ~r[0], sz, a};
        core_wdata <= w;
        sec_rd <= r[1];
        secondary_data_addr <= sa;
        #1;
        chk(64'({ram_rd | ram_wr, flash_req.rd | flash_req.wr, peripheral_reg_bus.rd | peripheral_reg_bus.wr,
             ext_req.rd | ext_req.wr}), 64'(tg));
        chk(64'({ram_wr, flash_req.wr, peripheral_reg_bus.wr, ext_req.wr}), 64'(r[0] ? 4'h0 : tg));
        tw = tg[2] ? {flash_req.addr, flash_req.wdata} : tg[1] ? {peripheral_reg_bus.addr, peripheral_reg_bus.wdata}
            : {ext_req.addr, ext_req.wdata};
        if (!r[0] && !tg[3]) chk(64'(tw), 64'({wa, sz == 2'h0 ? {w[7:0], w[7:0]} : w[15:0]}));
        chk(64'(fiu_ctl_sel), 64'((wa & `CSBF_FIU_MASK) == `CSBF_FIU_BASE));
        chk(64'(ram2_rd), 64'(r[1] & r[4]));
        if (tg[3]) begin
            chk(64'({ram_addr, ram_be}), 64'({wa, sz == 2'h2 ? 4'hF : sz != 2'h0 ? 4'h3 : r[3] ? 4'h2 : 4'h1}));
            if (!r[0]) chk(64'(sz == 2'h2 ? ram_wdata : {16'h0, ram_wdata[15:0]}),
                64'(sz == 2'h2 ? w : sz == 2'h0 ? {16'h0, w[7:0], w[7:0]} : {16'h0, w[15:0]}));
        end
        if (tg[1] && !r[0] && sz == 2'h1) chk(64'(peripheral_reg_bus.wdata), 64'(w[15:0]));
        d = tg[3] ? {ex(wa, 16'h1234), ex(wa, 16'h0000)} :
            {16'h0, ex(wa, tg[2] ? 16'h3C3C : tg[1] ? 16'h6969 : 16'hC3C3)};
        e = sz == 2'h2 ? d : sz == 2'h0 ? {24'h0, r[3] ? d[15:8] : d[7:0]} : {16'h0, d[15:0]};
        if (r[0]) qr.push_back({cyc + 1, e});
        if (r[1]) qs.push_back({cyc + 1, 16'h0, r[4] ? ex(sa, 16'h0F0F) : 16'h0});
    endtask

    // ==========================================================
    // Answer monitor
    always @(negedge ref_clk) begin
        if (prog_rvalid === 1'b1) take(qp, {16'h0, prog_rdata});
        if (pri_rvalid === 1'b1) take(qr, pri_rdata);
        if (sec_rvalid === 1'b1) take(qs, {16'h0, secondary_read_bus});
    end

    // ==========================================================
    // Sequence
    initial begin
        logic [31:0] r;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        chk_idle();
        for (int i = 0; i < 40; i++) begin
            r = nxt();
            prog_op(r[0], r[28:8]);
        end
        // Every size code against every region, back to back
        for (int i = 0; i < 200; i++) pri_op(2'(i / 5 % 4), i % 5);
        // Reset in mid-run must clear the read data that the outputs still hold
        @(posedge ref_clk);
        pri_req <= '0;
        sec_rd <= 1'b0;
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        chk_idle();
        prog_op(1'b1, 21'h000123);
        @(posedge ref_clk);
        prog_rd <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(64'(qp.size() + qr.size() + qs.size()), 64'h0);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        print_verdict();
    end
endmodule
